// ### src/nhisp_pkg.sv
// constants and types of the host serial slave port
//
// Contract
// R01 - device is only ever a slave on the two-wire bus, up to 3.4 MBaud; at the 10 MHz sys clock the port cannot follow 3.4 MBaud.
// R02 - standard 100 kHz, fast 400 kHz and high-speed 3.4 MHz clock classes; the 10 MHz sys clock is too slow for the 3.4 MHz class.
// R03 - in standby, only a transaction carrying our own address wakes the port.
// R04 - dedicated host attention output for flow control, active level selectable.
// R05 - device may hold clock low to pause; master waits until released.
// R06 - no general call, no 10-bit addressing, no fast-mode-plus.
// R07 - seven-bit slave addresses only, followed by a direction bit.
// R08 - address is 0,1,0,1,0, select bit1, select bit0, then direction.
// R09 - own shift register, bit timing and address compare, no processor help.
// R10 - configured as host link, four shared pins become select, clock, data.
// R11 - acknowledge only a matching address; leave data released otherwise.
package nhisp_pkg;

  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int MAX_BAUD = 3_400_000;
  localparam int STD_SCL_HZ = 100_000;
  localparam int FAST_SCL_HZ = 400_000;
  localparam int HS_SCL_HZ = 3_400_000;
  // sys clocks per high-speed clock period, rounded down
  localparam int HS_PERIOD_CYC = SYS_CLK_HZ / HS_SCL_HZ;

  localparam int SYNC_STAGES = 3;
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 4;

  localparam logic [4:0] ADDR_HEADER = 5'h0A;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] FULL_BYTE = 4'h8;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  typedef enum logic [3:0] {
    NHISP_IDLE,
    NHISP_ADDR,
    NHISP_ADDR_ACK,
    NHISP_RX,
    NHISP_RX_FULL,
    NHISP_RX_ACK,
    NHISP_TX_LOAD,
    NHISP_TX,
    NHISP_TX_ACK,
    NHISP_TX_NEXT
  } nhisp_state_t;

  function automatic logic [6:0] nhisp_own_addr(input logic sel1, input logic sel0);
    nhisp_own_addr = {ADDR_HEADER, sel1, sel0};
  endfunction

endpackage

// ### src/nhisp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nhisp_fifo
  import nhisp_pkg::*;
#(
  parameter int WIDTH = BYTE_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } nhisp_fifo_st_t;

  nhisp_fifo_st_t st_reg;
  nhisp_fifo_st_t st_next;
  logic push;
  logic pop;

  assign o_in_ready = st_reg.cnt != CW'(DEPTH);
  assign o_out_valid = st_reg.cnt != '0;
  assign o_out_data = st_reg.mem[st_reg.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = i_in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ### src/nhisp_port.sv
// host serial slave port: bus engine, receive fifo, attention line
`timescale 1ns/1ps
`default_nettype none
module nhisp_port
  import nhisp_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // configuration
  input wire logic i_link_select,
  input wire logic i_attn_active_high,
  input wire logic i_standby,
  // shared pins in serial-bus use
  input wire logic i_addr_select_bit0_pin,
  input wire logic i_addr_select_bit1_pin,
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe_n,
  input wire logic i_serial_data_pin,
  output logic o_serial_data_pin,
  output logic o_serial_data_pin_oe_n,
  // bytes received from the host
  output logic o_rx_valid,
  output logic [BYTE_BITS-1:0] o_rx_data,
  input wire logic i_rx_ready,
  // bytes to send to the host
  input wire logic i_tx_valid,
  input wire logic [BYTE_BITS-1:0] i_tx_data,
  output logic o_tx_ready,
  // status
  output logic o_host_attention,
  output logic o_wake,
  output logic o_busy
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] scl_sy;
    logic [SYNC_STAGES-1:0] sda_sy;
    logic [SYNC_STAGES-1:0] a0_sy;
    logic [SYNC_STAGES-1:0] a1_sy;
    logic scl;
    logic sda;
    logic a0;
    logic a1;
    nhisp_state_t state;
    logic [BYTE_BITS-1:0] shreg;
    logic [3:0] bitcnt;
    logic sda_low;
    logic scl_low;
    logic push;
    logic wake;
    logic attn;
  } nhisp_st_t;

  nhisp_st_t st_reg;
  nhisp_st_t st_next;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic fifo_in_ready;
  logic addr_match;
  logic sda_new;
  logic scl_new;

  // filtered levels: a change counts once second and third stage agree
  assign scl_new = (st_reg.scl_sy[1] == st_reg.scl_sy[2]) ? st_reg.scl_sy[2] : st_reg.scl;
  assign sda_new = (st_reg.sda_sy[1] == st_reg.sda_sy[2]) ? st_reg.sda_sy[2] : st_reg.sda;
  assign scl_rise = scl_new && !st_reg.scl;
  assign scl_fall = !scl_new && st_reg.scl;
  assign start_det = st_reg.scl && scl_new && st_reg.sda && !sda_new;
  assign stop_det = st_reg.scl && scl_new && !st_reg.sda && sda_new;

  // only 01010 + select pins match; general call and 10-bit headers never do
  assign addr_match = st_reg.shreg[7:1] == nhisp_own_addr(st_reg.a1, st_reg.a0); // [R07] [R08] [R06]

  assign o_tx_ready = st_reg.state == NHISP_TX_LOAD && scl_new == 1'b0;

  // open-drain pins: only ever pull low, enable active low
  assign o_serial_clock_pin = 1'b0;
  assign o_serial_clock_pin_oe_n = !st_reg.scl_low; // [R05]
  assign o_serial_data_pin = 1'b0;
  assign o_serial_data_pin_oe_n = !st_reg.sda_low;
  assign o_host_attention = st_reg.attn;
  assign o_wake = st_reg.wake;
  assign o_busy = st_reg.state != NHISP_IDLE;

  nhisp_fifo #(
    .WIDTH(BYTE_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(st_reg.push),
    .i_in_data(st_reg.shreg),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready)
  );

  always_comb begin
    st_next = st_reg;
    st_next.push = 1'b0;
    st_next.wake = 1'b0;
    st_next.scl_sy = {st_reg.scl_sy[1:0], i_serial_clock_pin};
    st_next.sda_sy = {st_reg.sda_sy[1:0], i_serial_data_pin};
    st_next.a0_sy = {st_reg.a0_sy[1:0], i_addr_select_bit0_pin};
    st_next.a1_sy = {st_reg.a1_sy[1:0], i_addr_select_bit1_pin};
    st_next.scl = scl_new;
    st_next.sda = sda_new;
    if (st_reg.a0_sy[1] == st_reg.a0_sy[2]) begin
      st_next.a0 = st_reg.a0_sy[2]; // [R10]
    end
    if (st_reg.a1_sy[1] == st_reg.a1_sy[2]) begin
      st_next.a1 = st_reg.a1_sy[2]; // [R10]
    end
    // attention: data waiting for the host, polarity chosen by config
    st_next.attn = !(i_tx_valid ^ i_attn_active_high); // [R04]

    unique case (st_reg.state)
      NHISP_IDLE: begin
        st_next.sda_low = 1'b0;
        st_next.scl_low = 1'b0;
      end
      NHISP_ADDR: begin
        if (scl_rise) begin
          st_next.shreg = {st_reg.shreg[6:0], sda_new}; // [R09]
          st_next.bitcnt = st_reg.bitcnt + 1'b1;
        end else if (scl_fall && st_reg.bitcnt == FULL_BYTE) begin
          if (addr_match) begin
            st_next.sda_low = 1'b1; // [R11]
            st_next.wake = i_standby; // [R03]
            st_next.state = NHISP_ADDR_ACK;
          end else begin
            st_next.state = NHISP_IDLE; // [R11] [R03]
          end
        end
      end
      NHISP_ADDR_ACK: begin
        if (scl_fall) begin
          st_next.sda_low = 1'b0;
          st_next.bitcnt = '0;
          st_next.scl_low = st_reg.shreg[0];
          st_next.state = st_reg.shreg[0] ? NHISP_TX_LOAD : NHISP_RX;
        end
      end
      NHISP_RX: begin
        if (scl_rise) begin
          st_next.shreg = {st_reg.shreg[6:0], sda_new}; // [R09]
          st_next.bitcnt = st_reg.bitcnt + 1'b1;
        end else if (scl_fall && st_reg.bitcnt == FULL_BYTE) begin
          if (fifo_in_ready) begin
            st_next.push = 1'b1;
            st_next.sda_low = 1'b1;
            st_next.state = NHISP_RX_ACK;
          end else begin
            // fifo full: hold the clock low until room appears
            st_next.scl_low = 1'b1; // [R05]
            st_next.state = NHISP_RX_FULL;
          end
        end
      end
      NHISP_RX_FULL: begin
        if (fifo_in_ready) begin
          st_next.push = 1'b1;
          st_next.sda_low = 1'b1;
          st_next.scl_low = 1'b0; // [R05]
          st_next.state = NHISP_RX_ACK;
        end
      end
      NHISP_RX_ACK: begin
        if (scl_fall) begin
          st_next.sda_low = 1'b0;
          st_next.bitcnt = '0;
          st_next.state = NHISP_RX;
        end
      end
      NHISP_TX_LOAD: begin
        // clock held low until a byte is on offer
        st_next.scl_low = 1'b1; // [R05]
        if (i_tx_valid && !scl_new) begin
          st_next.shreg = i_tx_data;
          st_next.sda_low = !i_tx_data[7];
          st_next.scl_low = 1'b0;
          st_next.bitcnt = '0;
          st_next.state = NHISP_TX;
        end
      end
      NHISP_TX: begin
        if (scl_fall) begin
          if (st_reg.bitcnt == LAST_BIT) begin
            st_next.sda_low = 1'b0;
            st_next.state = NHISP_TX_ACK;
          end else begin
            st_next.shreg = {st_reg.shreg[6:0], 1'b0}; // [R09]
            st_next.sda_low = !st_reg.shreg[6];
            st_next.bitcnt = st_reg.bitcnt + 1'b1;
          end
        end
      end
      NHISP_TX_ACK: begin
        if (scl_rise) begin
          // master nack ends the read; wait for stop or start
          st_next.state = sda_new ? NHISP_IDLE : NHISP_TX_NEXT;
        end
      end
      NHISP_TX_NEXT: begin
        if (scl_fall) begin
          st_next.scl_low = 1'b1;
          st_next.state = NHISP_TX_LOAD;
        end
      end
    endcase

    // bus conditions override any phase; device never originates them
    if (start_det) begin
      st_next.state = NHISP_ADDR; // [R01]
      st_next.bitcnt = '0;
      st_next.sda_low = 1'b0;
      st_next.scl_low = 1'b0;
      st_next.push = 1'b0;
    end else if (stop_det) begin
      st_next.state = NHISP_IDLE;
      st_next.sda_low = 1'b0;
      st_next.scl_low = 1'b0;
      st_next.push = 1'b0;
    end

    // pins not given to the serial bus: port stays silent
    if (!i_link_select) begin
      st_next.state = NHISP_IDLE; // [R10]
      st_next.sda_low = 1'b0;
      st_next.scl_low = 1'b0;
      st_next.push = 1'b0;
      st_next.wake = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.scl_sy <= SYNC_RESET;
      st_reg.sda_sy <= SYNC_RESET;
      st_reg.scl <= 1'b1;
      st_reg.sda <= 1'b1;
      st_reg.state <= NHISP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // bit rate cap: sampled at 10 MHz, each clock phase must last two sys
  // clocks after the three-stage filter; true 3.4 MHz timing needs a
  // faster system clock than this one [R02]
endmodule
`default_nettype wire

// ### test/nhisp_port_properties.sv
// pin and stream assertions of the host serial slave port
`timescale 1ns/1ps
`default_nettype none
module nhisp_port_properties
  import nhisp_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // inputs watched
  input wire logic i_link_select,
  input wire logic i_attn_active_high,
  input wire logic i_standby,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  // outputs watched
  input wire logic o_serial_clock_pin,
  input wire logic o_serial_clock_pin_oe_n,
  input wire logic o_serial_data_pin,
  input wire logic o_serial_data_pin_oe_n,
  input wire logic o_rx_valid,
  input wire logic [BYTE_BITS-1:0] o_rx_data,
  input wire logic o_tx_ready,
  input wire logic o_host_attention,
  input wire logic o_wake,
  input wire logic o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence take_s;
    o_tx_ready && i_tx_valid;
  endsequence
  sequence wake_s;
    $past(i_standby) && o_busy ##1 !o_wake;
  endsequence
  scl_value_zero_a: assert property (o_serial_clock_pin == 1'b0)
    else $error("clock line driven high");
  sda_value_zero_a: assert property (o_serial_data_pin == 1'b0)
    else $error("data line driven high");
  link_off_release_a: assert property (!i_link_select [*2] |->
    o_serial_clock_pin_oe_n && o_serial_data_pin_oe_n)
    else $error("pins held with link off");
  attn_level_a: assert property (!$past(i_rst) |->
    o_host_attention == ($past(i_tx_valid) ~^ $past(i_attn_active_high)))
    else $error("attention level wrong");
  wake_pulse_a: assert property (o_wake |-> wake_s)
    else $error("wake pulse wrong");
  tx_take_release_a: assert property (take_s |=> o_serial_clock_pin_oe_n)
    else $error("clock not released after byte taken");
  rx_hold_a: assert property (o_rx_valid && !i_rx_ready |=>
    o_rx_valid && $stable(o_rx_data))
    else $error("received byte not held");
  idle_release_a: assert property (!o_busy [*2] |->
    o_serial_clock_pin_oe_n && o_serial_data_pin_oe_n)
    else $error("pins held while idle");
endmodule
`default_nettype wire

// ### test/nhisp_host_model.sv
// behavioural host bus master on the open-drain lines
`timescale 1ns/1ps
`default_nettype none
module nhisp_host_model (
  // resolved wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // host line values, 1 = released
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // 800 ns bit: 500 ns low, 300 ns high
  task automatic pulse(input logic b, output logic r);
    #200 o_sda = b;
    #300 o_scl = 1'b1;
    // poll on the 100 ns grid so later edges stay off the sys clock edge
    while (i_scl !== 1'b1) #100;
    #200 r = i_sda;
    #100 o_scl = 1'b0;
  endtask
  task automatic start;
    #200 o_sda = 1'b1;
    #300 o_scl = 1'b1;
    #300 o_sda = 1'b0;
    #300 o_scl = 1'b0;
  endtask
  task automatic stop;
    #200 o_sda = 1'b0;
    #300 o_scl = 1'b1;
    #300 o_sda = 1'b1;
    #300;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(d[i], r);
    pulse(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(!ack, r);
  endtask
endmodule
`default_nettype wire

// ### test/nhisp_port_tb.sv
// self-checking bench of the host serial slave port
`timescale 1ns/1ps
`default_nettype none
module nhisp_port_tb;
  import nhisp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, link = 1'b1, pol = 1'b1, stby = 1'b1;
  logic s0 = 1'b1, s1 = 1'b0, rx_rdy = 1'b0, tx_vld = 1'b0, woke = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic [7:0] rx_d;
  logic h_scl, h_sda, scl_oe_n, sda_oe_n, rx_vld, tx_rdy, attn, wake, busy;
  wire scl = h_scl & scl_oe_n;
  wire sda = h_sda & sda_oe_n;
  int errors = 0, check_count = 0, cycles = 0;
  always #50 clk = !clk;
  nhisp_port u_dut (.i_sys_clk(clk), .i_rst(rst), .i_link_select(link),
    .i_attn_active_high(pol), .i_standby(stby), .i_addr_select_bit0_pin(s0),
    .i_addr_select_bit1_pin(s1), .i_serial_clock_pin(scl), .o_serial_clock_pin(),
    .o_serial_clock_pin_oe_n(scl_oe_n), .i_serial_data_pin(sda), .o_serial_data_pin(),
    .o_serial_data_pin_oe_n(sda_oe_n), .o_rx_valid(rx_vld), .o_rx_data(rx_d),
    .i_rx_ready(rx_rdy), .i_tx_valid(tx_vld), .i_tx_data(tx_d), .o_tx_ready(tx_rdy),
    .o_host_attention(attn), .o_wake(wake), .o_busy(busy));
  nhisp_host_model u_host (.i_scl(scl), .i_sda(sda), .o_scl(h_scl), .o_sda(h_sda));
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (wake) woke = 1'b1;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  // six address frames per select, all four selects: each own address, general call, ten-bit header
  task automatic t_addr;
    logic ack;
    logic [7:0] a;
    for (int s = 0; s < 4; s++) begin
      @(negedge clk) {s1, s0} = 2'(s);
      for (int k = 0; k < 6; k++) begin
        a = (k < 4) ? {5'h0A, 2'(k), 1'b0} : ((k == 4) ? 8'h00 : 8'hF0);
        woke = 1'b0;
        u_host.start();
        u_host.wr(a, ack);
        u_host.stop();
        check(ack === (k == s), "address ack");
        check(woke === (k == s), "wake on own address");
      end
    end
  endtask
  // five bytes into the four-word fifo, host stalled, then drained
  task automatic t_fill;
    logic ack;
    logic [7:0] d [5] = '{8'hA5, 8'h3C, 8'h00, 8'hFF, 8'h5A};
    @(negedge clk) {s1, s0} = 2'b01;
    fork
      begin
        u_host.start();
        u_host.wr(8'h52, ack);
        for (int i = 0; i < 5; i++) u_host.wr(d[i], ack);
        u_host.stop();
      end
      begin
        for (int n = 0; n < 2000 && scl_oe_n !== 1'b0; n++) @(negedge clk);
        repeat (20) @(negedge clk);
        check(scl === 1'b0, "clock not held while full");
        for (int i = 0; i < 5; i++) begin
          for (int n = 0; n < 200 && rx_vld !== 1'b1; n++) @(negedge clk);
          check(rx_d === d[i], "received byte");
          rx_rdy = 1'b1;
          @(negedge clk) rx_rdy = 1'b0;
        end
      end
    join
    check(rx_vld === 1'b0, "fifo not empty");
  endtask
  // two-byte read under both attention polarities, second byte late
  task automatic t_read;
    logic ack;
    logic [7:0] q;
    logic [7:0] d [2] = '{8'h96, 8'h0F};
    for (int p = 0; p < 2; p++) begin
      @(negedge clk) pol = p[0];
      @(negedge clk);
      check(attn === !pol, "attention idle level");
      fork
        begin
          u_host.start();
          u_host.wr(8'h53, ack);
          u_host.rd(q, 1'b1);
          check(q === d[0], "first read byte");
          u_host.rd(q, 1'b0);
          check(q === d[1], "second read byte");
          u_host.stop();
        end
        for (int i = 0; i < 2; i++) begin
          repeat (i * 150) @(negedge clk);
          tx_d = d[i];
          tx_vld = 1'b1;
          @(negedge clk) check(attn === pol, "attention while pending");
          for (int n = 0; n < 400 && tx_rdy !== 1'b1; n++) @(negedge clk);
          @(negedge clk) tx_vld = 1'b0;
        end
      join
    end
  endtask
  // link deselected, then awake device addressed
  task automatic t_link_off;
    logic ack;
    @(negedge clk) link = 1'b0;
    u_host.start();
    u_host.wr(8'h52, ack);
    u_host.stop();
    check(ack === 1'b0, "answer with link off");
    @(negedge clk) link = 1'b1;
    stby = 1'b0;
    woke = 1'b0;
    u_host.start();
    u_host.wr(8'h52, ack);
    u_host.stop();
    check(ack === 1'b1 && woke === 1'b0, "awake address frame");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_addr();
    t_fill();
    t_read();
    t_link_off();
    report_and_stop();
  end
endmodule
bind nhisp_port nhisp_port_properties u_props (.i_sys_clk, .i_rst, .i_link_select,
  .i_attn_active_high, .i_standby, .i_rx_ready, .i_tx_valid, .o_serial_clock_pin,
  .o_serial_clock_pin_oe_n, .o_serial_data_pin, .o_serial_data_pin_oe_n, .o_rx_valid,
  .o_rx_data, .o_tx_ready, .o_host_attention, .o_wake, .o_busy);
`default_nettype wire
